// >>> hw/sruc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit 2 of distribution control powers down the sync circuitry.
// - Bit 1 of distribution control powers down the distribution reference.
// - Soft-sync bit 0 acts as the sync pin inverted; 1 means pin low.
// - While soft sync is 1, selected channels are held static.
// - A 1-to-0 change of soft sync starts a synchronisation.
// - Soft sync reads 0 after reset, outputs running.
// - Writing 1 to update bit 0 copies all buffer registers to active.
// - The update bit clears itself after the transfer.
module sruc_top (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [9:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        SYNC_PIN_N,
    output logic      [7:0]  RDATA,
    output logic             SYNC_PD,
    output logic             DIST_REF_PD,
    output logic             SYNC_HOLD,
    output logic             SYNC_START,
    output logic             UPDATE_PULSE
);
    typedef struct packed {
        logic [7:0] buf_ctrl;
        logic [7:0] act_ctrl;
        logic       update;
        logic [7:0] rdata;
        logic       sync_pd;
        logic       ref_pd;
    } sruc_top_type;

    sruc_top_type s_r;
    sruc_top_type s_nxt;
    logic         hold_q;
    logic         start_q;
    logic         sync_req;
    logic         wr_ctrl;
    logic         wr_upd;
    logic         rd_ctrl;
    logic         rd_upd;
    logic         upd_cmd;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = (a == r);
    endfunction : hit

    // Pin low or soft sync high both request the static hold.
    assign sync_req = s_r.act_ctrl[sruc_pkg::SOFT_SYNC_BIT] | ~SYNC_PIN_N;

    assign wr_ctrl = WR & hit(ADDR, sruc_pkg::DIST_CTRL_ADDR);
    assign wr_upd  = WR & hit(ADDR, sruc_pkg::UPDATE_ADDR);
    assign rd_ctrl = RD & hit(ADDR, sruc_pkg::DIST_CTRL_ADDR);
    assign rd_upd  = RD & hit(ADDR, sruc_pkg::UPDATE_ADDR);
    assign upd_cmd = wr_upd & WDATA[sruc_pkg::UPDATE_BIT];

    always_comb begin
        s_nxt        = s_r;
        s_nxt.update = 1'b0;
        s_nxt.rdata  = sruc_pkg::UNMAPPED_READ;
        if (wr_ctrl) begin
            s_nxt.buf_ctrl = WDATA & sruc_pkg::DIST_CTRL_MASK;
        end
        if (upd_cmd) begin
            s_nxt.update = 1'b1;
        end
        if (s_r.update) begin
            s_nxt.act_ctrl = s_r.buf_ctrl;
        end
        if (rd_ctrl) begin
            s_nxt.rdata = s_r.buf_ctrl;
        end
        if (rd_upd) begin
            s_nxt.rdata = {7'h00, s_r.update};
        end
        s_nxt.sync_pd = s_nxt.act_ctrl[sruc_pkg::PD_SYNC_BIT];
        s_nxt.ref_pd  = s_nxt.act_ctrl[sruc_pkg::PD_REF_BIT];
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r          <= '0;
            s_r.buf_ctrl <= sruc_pkg::DIST_CTRL_RESET;
            s_r.act_ctrl <= sruc_pkg::DIST_CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    sruc_sync_edge u_edge (
        .CLK       (CLK),
        .RST       (RST),
        .hold_in   (sync_req),
        .enable    (~s_r.sync_pd),
        .hold_out  (hold_q),
        .start_out (start_q)
    );

    assign RDATA        = s_r.rdata;
    assign SYNC_PD      = s_r.sync_pd;
    assign DIST_REF_PD  = s_r.ref_pd;
    assign SYNC_HOLD    = hold_q;
    assign SYNC_START   = start_q;
    assign UPDATE_PULSE = s_r.update;

    property p_update_copies;
        @(posedge CLK) disable iff (RST)
        UPDATE_PULSE |=> (s_r.act_ctrl == $past(s_r.buf_ctrl));
    endproperty
    a_update_copies: assert property (p_update_copies) else $error("update did not copy");

    property p_update_self_clear;
        @(posedge CLK) disable iff (RST)
        !upd_cmd |=> !UPDATE_PULSE;
    endproperty
    a_update_self_clear: assert property (p_update_self_clear) else $error("update stuck");

    property p_buffer_isolated;
        @(posedge CLK) disable iff (RST)
        !UPDATE_PULSE |=> $stable(s_r.act_ctrl);
    endproperty
    a_buffer_isolated: assert property (p_buffer_isolated) else $error("active changed");

    property p_sync_pd;
        @(posedge CLK) disable iff (RST)
        UPDATE_PULSE |=> SYNC_PD == $past(s_r.buf_ctrl[sruc_pkg::PD_SYNC_BIT]);
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("sync power-down wrong");

    property p_ref_pd;
        @(posedge CLK) disable iff (RST)
        UPDATE_PULSE |=> DIST_REF_PD == $past(s_r.buf_ctrl[sruc_pkg::PD_REF_BIT]);
    endproperty
    a_ref_pd: assert property (p_ref_pd) else $error("reference power-down wrong");

    property p_hold;
        @(posedge CLK) disable iff (RST)
        (s_r.act_ctrl[sruc_pkg::SOFT_SYNC_BIT] && !SYNC_PD) |=> SYNC_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("hold missing");

    sequence s_release;
        sync_req ##1 (!sync_req && !SYNC_PD);
    endsequence
    property p_start;
        @(posedge CLK) disable iff (RST)
        s_release |=> SYNC_START;
    endproperty
    a_start: assert property (p_start) else $error("sync start missing");

    property p_start_gated;
        @(posedge CLK) disable iff (RST)
        SYNC_START |-> $past(sync_req, 2) && !$past(sync_req) && !$past(SYNC_PD);
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("spurious start");

    property p_reset_val;
        @(posedge CLK) $fell(RST) |-> !s_r.buf_ctrl[sruc_pkg::SOFT_SYNC_BIT]
            && !s_r.act_ctrl[sruc_pkg::SOFT_SYNC_BIT] && !SYNC_HOLD;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("soft sync not zero");

    property p_pd_blocks;
        @(posedge CLK) disable iff (RST)
        SYNC_PD |=> !SYNC_HOLD && !SYNC_START;
    endproperty
    a_pd_blocks: assert property (p_pd_blocks) else $error("sync while powered down");

    property p_pin_hold;
        @(posedge CLK) disable iff (RST)
        (!SYNC_PIN_N && !SYNC_PD) |=> SYNC_HOLD;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin hold missing");

    property p_hold_release;
        @(posedge CLK) disable iff (RST)
        !sync_req |=> !SYNC_HOLD;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold not released");

    property p_start_once;
        @(posedge CLK) disable iff (RST)
        SYNC_START |=> !SYNC_START;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start too long");

    property p_update_trigger;
        @(posedge CLK) disable iff (RST)
        upd_cmd |=> UPDATE_PULSE;
    endproperty
    a_update_trigger: assert property (p_update_trigger) else $error("update not started");

    sequence s_commit;
        upd_cmd ##1 UPDATE_PULSE;
    endsequence
    property p_commit_clear;
        @(posedge CLK) disable iff (RST)
        s_commit |=> !UPDATE_PULSE || $past(upd_cmd);
    endproperty
    a_commit_clear: assert property (p_commit_clear) else $error("update not cleared");

    property p_read_update;
        @(posedge CLK) disable iff (RST)
        rd_upd |=> RDATA == {7'h00, $past(UPDATE_PULSE)};
    endproperty
    a_read_update: assert property (p_read_update) else $error("update readback wrong");

    property p_buf_write;
        @(posedge CLK) disable iff (RST)
        wr_ctrl |=> s_r.buf_ctrl == ($past(WDATA) & sruc_pkg::DIST_CTRL_MASK);
    endproperty
    a_buf_write: assert property (p_buf_write) else $error("buffer write lost");

    property p_pd_stable;
        @(posedge CLK) disable iff (RST)
        !UPDATE_PULSE |=> $stable(SYNC_PD) && $stable(DIST_REF_PD);
    endproperty
    a_pd_stable: assert property (p_pd_stable) else $error("power-down moved");

    property p_read_buffer;
        @(posedge CLK) disable iff (RST)
        rd_ctrl |=> RDATA == $past(s_r.buf_ctrl);
    endproperty
    a_read_buffer: assert property (p_read_buffer) else $error("buffer readback wrong");
endmodule : sruc_top
`default_nettype wire

// >>> common/sruc_pkg.sv
`default_nettype none
package sruc_pkg;
    localparam int          ADDR_W          = 10;
    localparam int          DATA_W          = 8;
    localparam logic [9:0]  DIST_CTRL_ADDR  = 10'h230;
    localparam logic [9:0]  UPDATE_ADDR     = 10'h232;
    localparam int          PD_SYNC_BIT     = 2;
    localparam int          PD_REF_BIT      = 1;
    localparam int          SOFT_SYNC_BIT   = 0;
    localparam int          UPDATE_BIT      = 0;
    localparam logic [7:0]  DIST_CTRL_RESET = 8'h00;
    localparam logic [7:0]  DIST_CTRL_MASK  = 8'h07;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
endpackage : sruc_pkg
`default_nettype wire

// >>> hw/sruc_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Tracks the held sync level and emits a one-cycle start pulse on its release.
module sruc_sync_edge (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic hold_in,
    input  wire logic enable,
    output logic      hold_out,
    output logic      start_out
);
    typedef struct packed {
        logic prev;
        logic hold;
        logic start;
    } sruc_edge_type;

    sruc_edge_type s_r;
    sruc_edge_type s_nxt;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.prev  = hold_in;
        s_nxt.hold  = hold_in & enable;
        s_nxt.start = s_r.prev & ~hold_in & enable;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hold_out  = s_r.hold;
    assign start_out = s_r.start;
endmodule : sruc_sync_edge
`default_nettype wire

// >>> dv/sync_and_register_update_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sync_and_register_update_control_tb_top;
    logic       CLK        = 1'b0;
    logic       RST        = 1'b1;
    logic [9:0] ADDR       = 10'h000;
    logic [7:0] WDATA      = 8'h00;
    logic       WR         = 1'b0;
    logic       RD         = 1'b0;
    logic       SYNC_PIN_N = 1'b1;
    logic [7:0] RDATA;
    logic       SYNC_PD, DIST_REF_PD, SYNC_HOLD, SYNC_START, UPDATE_PULSE;
    int         n_fail       = 0;
    int         total_checks = 0;
    localparam int W_HOLD  = 0;
    localparam int W_START = 1;
    localparam int W_PD    = 2;
    always #5 CLK = ~CLK;
    sruc_top dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .SYNC_PIN_N(SYNC_PIN_N), .RDATA(RDATA), .SYNC_PD(SYNC_PD), .DIST_REF_PD(DIST_REF_PD),
        .SYNC_HOLD(SYNC_HOLD), .SYNC_START(SYNC_START), .UPDATE_PULSE(UPDATE_PULSE));
    task end_of_test;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic logic pick(input int sel);
        case (sel)
            W_HOLD:  pick = SYNC_HOLD;
            W_START: pick = SYNC_START;
            default: pick = SYNC_PD;
        endcase
    endfunction : pick
    task automatic wait_hi(input int sel, input string n);
        int i;
        i = 0;
        while (pick(sel) !== 1'b1 && i < 8) begin
            @(posedge CLK);
            #1;
            i++;
        end
        chk(n, 8'h01, {7'h00, pick(sel)});
        if (pick(sel) !== 1'b1) end_of_test;
    endtask : wait_hi
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] e, input string n);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(n, e, RDATA);
    endtask : rd
    task upd;
        wr(sruc_pkg::UPDATE_ADDR, 8'h01);
        #1;
        chk("update_pulse", 8'h01, {7'h00, UPDATE_PULSE});
        @(posedge CLK);
        #1;
        chk("update_pulse_end", 8'h00, {7'h00, UPDATE_PULSE});
    endtask : upd
    task t_soft;
        rd(sruc_pkg::DIST_CTRL_ADDR, 8'h00, "ctrl_reset");
        chk("hold_reset", 8'h00, {7'h00, SYNC_HOLD});
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'h01);
        repeat (3) @(posedge CLK);
        #1;
        chk("hold_before_update", 8'h00, {7'h00, SYNC_HOLD});
        rd(sruc_pkg::DIST_CTRL_ADDR, 8'h01, "buffer_readback");
        upd;
        rd(sruc_pkg::UPDATE_ADDR, 8'h00, "update_self_clear");
        wait_hi(W_HOLD, "soft_hold");
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'h00);
        upd;
        wait_hi(W_START, "soft_start");
        @(posedge CLK);
        #1;
        chk("start_one_cycle", 8'h00, {7'h00, SYNC_START});
        chk("hold_released", 8'h00, {7'h00, SYNC_HOLD});
        $display("t_soft done");
    endtask : t_soft
    task t_pin;
        @(posedge CLK);
        SYNC_PIN_N <= 1'b0;
        wait_hi(W_HOLD, "pin_hold");
        @(posedge CLK);
        SYNC_PIN_N <= 1'b1;
        wait_hi(W_START, "pin_start");
        chk("pin_hold_released", 8'h00, {7'h00, SYNC_HOLD});
        $display("t_pin done");
    endtask : t_pin
    task t_pd;
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'hfe);
        #1;
        chk("pd_before_update", 8'h00, {6'h00, SYNC_PD, DIST_REF_PD});
        rd(sruc_pkg::DIST_CTRL_ADDR, 8'h06, "reserved_bits");
        upd;
        wait_hi(W_PD, "sync_pd");
        chk("dist_ref_pd", 8'h01, {7'h00, DIST_REF_PD});
        @(posedge CLK);
        SYNC_PIN_N <= 1'b0;
        repeat (4) begin
            @(posedge CLK);
            #1;
            chk("pd_no_hold", 8'h00, {7'h00, SYNC_HOLD});
        end
        @(posedge CLK);
        SYNC_PIN_N <= 1'b1;
        repeat (4) begin
            @(posedge CLK);
            #1;
            chk("no_hold_no_start", 8'h00, {6'h00, SYNC_HOLD, SYNC_START});
        end
        wr(10'h231, 8'hff);
        rd(10'h231, 8'h00, "unmapped");
        wr(sruc_pkg::UPDATE_ADDR, 8'h00);
        #1;
        chk("update_bit_clear", 8'h00, {7'h00, UPDATE_PULSE});
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'h02);
        upd;
        repeat (2) @(posedge CLK);
        #1;
        chk("ref_pd_only", 8'h01, {6'h00, SYNC_PD, DIST_REF_PD});
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'h00);
        upd;
        repeat (2) @(posedge CLK);
        #1;
        chk("pd_cleared", 8'h00, {6'h00, SYNC_PD, DIST_REF_PD});
        $display("t_pd done");
    endtask : t_pd
    task t_reset;
        wr(sruc_pkg::DIST_CTRL_ADDR, 8'h01);
        upd;
        wait_hi(W_HOLD, "hold_before_reset");
        @(posedge CLK);
        RST <= 1'b1;
        @(posedge CLK);
        #1;
        chk("hold_in_reset", 8'h00, {7'h00, SYNC_HOLD});
        @(posedge CLK);
        RST <= 1'b0;
        rd(sruc_pkg::DIST_CTRL_ADDR, 8'h00, "ctrl_after_reset");
        chk("quiet_after_reset", 8'h00, {6'h00, SYNC_HOLD, SYNC_START});
        $display("t_reset done");
    endtask : t_reset
    initial begin
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        t_soft;
        t_pin;
        t_pd;
        t_reset;
        end_of_test;
    end
endmodule : sync_and_register_update_control_tb_top
`default_nettype wire
